/* bench/iepr_core_model.sv */
// core-side model that takes vectors and returns from routines
`timescale 1ns/1ns
`default_nettype none
module iepr_core_model (
  // clock and reset
  input  wire logic clock_i,
  input  wire logic reset_n_i,
  // vectoring handshake
  input  wire logic irq_i,
  input  wire logic take_i,
  input  wire logic ret_i,
  output logic      ack_o,
  output logic      reti_o
);
  // ack only while the request line stands, one pulse at a time
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ack_o <= 1'b0;
      reti_o <= 1'b0;
    end else begin
      ack_o <= irq_i && take_i && !ack_o;
      reti_o <= ret_i && !reti_o;
    end
  end
endmodule
`default_nettype wire

/* bench/iepr_regs_checker.sv */
// assertion checker for the enable and priority register set
`timescale 1ns/1ns
`default_nettype none
module iepr_regs_checker
  import iepr_pkg::*;
#(
  parameter int unsigned ADDR_W = 12
) (
  // clock, reset and apb
  input wire logic              clock_i,
  input wire logic              reset_n_i,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // interrupt side
  input wire logic [NSRC-1:0]   irq_req_i,
  input wire logic              irq_ack_i,
  input wire logic              irq_reti_i,
  input wire logic              irq_o,
  input wire iepr_sel_type      irq_sel_o,
  input wire logic              usb_irq_enable_o,
  input wire logic              kbd_irq_enable_o,
  input wire logic              adc_irq_enable_o,
  input wire logic              spi_irq_enable_o,
  input wire logic              twi_irq_enable_o,
  input wire logic              card_irq_enable_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  wire logic wr_en = psel && penable && pwrite && paddr == 12'h2C4;
  wire logic rd_pr = psel && !penable && !pwrite && paddr inside {12'h2C4, 12'h2C8, 12'h2CC};

  a_usb_en_wr: assert property (wr_en |=> usb_irq_enable_o == $past(pwdata[6]))
    else $error("usb enable not taken from write");
  a_low_en_wr: assert property (wr_en |=> {kbd_irq_enable_o, adc_irq_enable_o,
    spi_irq_enable_o, twi_irq_enable_o, card_irq_enable_o} == $past(pwdata[4:0]))
    else $error("peripheral enables not taken from write");
  a_rsvd_read_zero: assert property (rd_pr |=> !prdata[7] && !prdata[5])
    else $error("reserved bit read as one");
  a_reset_clear: assert property ($rose(reset_n_i) |-> !irq_o && !usb_irq_enable_o)
    else $error("state not clear after reset");
  a_no_rsvd_index: assert property (irq_o |-> !(irq_sel_o.index inside {4'hC, 4'hE}))
    else $error("reserved source selected");
  a_usb_gated: assert property (irq_o && irq_sel_o.index == 4'hD |-> $past(usb_irq_enable_o))
    else $error("usb selected while masked");
  a_card_gated: assert property (irq_o && irq_sel_o.index == 4'h7 |-> $past(card_irq_enable_o))
    else $error("card selected while masked");
  a_winner_req: assert property (irq_o |-> (($past(irq_req_i) >> irq_sel_o.index) & 15'h1) != 0)
    else $error("selected source had no request");

  c_en_write: cover property (wr_en);
  c_irq_rise: cover property ($rose(irq_o));
  c_irq_ack: cover property (irq_o && irq_ack_i);
endmodule

bind iepr_regs iepr_regs_checker #(.ADDR_W(ADDR_W)) iepr_regs_checker_inst (
  .clock_i           (clock_i),
  .reset_n_i         (reset_n_i),
  .psel              (psel),
  .penable           (penable),
  .pwrite            (pwrite),
  .paddr             (paddr),
  .pwdata            (pwdata),
  .prdata            (prdata),
  .pready            (pready),
  .pslverr           (pslverr),
  .irq_req_i         (irq_req_i),
  .irq_ack_i         (irq_ack_i),
  .irq_reti_i        (irq_reti_i),
  .irq_o             (irq_o),
  .irq_sel_o         (irq_sel_o),
  .usb_irq_enable_o  (usb_irq_enable_o),
  .kbd_irq_enable_o  (kbd_irq_enable_o),
  .adc_irq_enable_o  (adc_irq_enable_o),
  .spi_irq_enable_o  (spi_irq_enable_o),
  .twi_irq_enable_o  (twi_irq_enable_o),
  .card_irq_enable_o (card_irq_enable_o)
);
`default_nettype wire

/* bench/iepr_regs_tb_top.sv */
// self-checking bench for the enable and priority register set
`timescale 1ns/1ns
`default_nettype none
module iepr_regs_tb_top;
  import iepr_pkg::*;
  localparam logic [11:0] AD [6] = '{12'h2A0, 12'h2C4, 12'h2C8, 12'h2CC, 12'h2DC, 12'h2E0};
  localparam logic [7:0]  MS [6] = '{8'hFF, 8'h5F, 8'h5F, 8'h5F, 8'h7F, 8'h7F};
  logic         clock_i, reset_n_i, psel, penable, pwrite, pready, pslverr;
  logic         irq_ack_i, irq_reti_i, irq_o, take, ret, er;
  logic         usb_irq_enable_o, kbd_irq_enable_o, adc_irq_enable_o;
  logic         spi_irq_enable_o, twi_irq_enable_o, card_irq_enable_o;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, rd;
  logic [14:0]  irq_req_i;
  iepr_sel_type irq_sel_o;
  logic [7:0]   m [6];
  logic [7:0]   d;
  logic [6:0]   x;
  int           k, seed;
  int           fail_count = 0;
  int           n_checks = 0;

  iepr_regs iepr_regs_inst (
    .clock_i           (clock_i),
    .reset_n_i         (reset_n_i),
    .psel              (psel),
    .penable           (penable),
    .pwrite            (pwrite),
    .paddr             (paddr),
    .pwdata            (pwdata),
    .prdata            (prdata),
    .pready            (pready),
    .pslverr           (pslverr),
    .irq_req_i         (irq_req_i),
    .irq_ack_i         (irq_ack_i),
    .irq_reti_i        (irq_reti_i),
    .irq_o             (irq_o),
    .irq_sel_o         (irq_sel_o),
    .usb_irq_enable_o  (usb_irq_enable_o),
    .kbd_irq_enable_o  (kbd_irq_enable_o),
    .adc_irq_enable_o  (adc_irq_enable_o),
    .spi_irq_enable_o  (spi_irq_enable_o),
    .twi_irq_enable_o  (twi_irq_enable_o),
    .card_irq_enable_o (card_irq_enable_o)
  );
  iepr_core_model iepr_core_model_inst (.clock_i(clock_i), .reset_n_i(reset_n_i),
    .irq_i(irq_o), .take_i(take), .ret_i(ret), .ack_o(irq_ack_i), .reti_o(irq_reti_i));

  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] v);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, v};
    @(posedge clock_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      fail_count++;
      wrap_up();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock_i);
  endtask

  task automatic wr(input int i, input logic [7:0] v);
    apb(AD[i], 1'b1, v & MS[i]);
    m[i] = v & MS[i];
  endtask

  task automatic rdk(input int i);
    apb(AD[i], 1'b0, 8'h00);
    chk(i > 3 ? rd & 32'hFFFF_FF7F : rd, {24'h0, m[i]});
  endtask

  // reference arbiter: highest level wins, ties go to the lower index
  function automatic logic [6:0] pick(input logic [14:0] r);
    int b, lv, best;
    logic e;
    pick = 7'h00;
    best = -1;
    for (int i = 0; i < 15; i++) begin
      b = (i == 13) ? 6 : ((i < 7) ? i : i - 7);
      lv = (i < 7) ? {m[4][b], m[5][b]} : {m[3][b], m[2][b]};
      e = (i < 7) ? m[0][b] : m[1][b];
      if (m[0][7] && r[i] && e && i != 12 && i != 14 && lv > best) begin
        best = lv;
        pick = {1'b1, 2'(lv), 4'(i)};
      end
    end
  endfunction

  initial begin
    reset_n_i = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    irq_req_i = '0;
    take = 1'b0;
    ret = 1'b0;
    m = '{default: 8'h00};
    seed = $urandom(32'h66836c49);
    repeat (2) @(posedge clock_i);
    reset_n_i <= 1'b1;
    @(posedge clock_i);
    for (int i = 0; i < 6; i++) rdk(i);
    chk({usb_irq_enable_o, kbd_irq_enable_o, card_irq_enable_o}, 32'h0);
    for (int i = 0; i < 16; i++) begin
      k = $urandom_range(5);
      d = 8'($urandom);
      d &= MS[k];
      wr(k, d);
      rdk(k);
      chk({usb_irq_enable_o, kbd_irq_enable_o, adc_irq_enable_o, spi_irq_enable_o,
        twi_irq_enable_o, card_irq_enable_o}, {m[1][6], m[1][4:0]});
    end
    apb(12'h2B0, 1'b0, 8'h00);
    chk(er, 32'h1);
    for (int i = 0; i < 40; i++) begin
      for (int j = 0; j < 6; j++) wr(j, 8'($urandom));
      irq_req_i <= 15'($urandom);
      repeat (2) @(posedge clock_i);
      x = pick(irq_req_i);
      chk(irq_o, x[6]);
      if (x[6]) chk(irq_sel_o, x);
    end
    irq_req_i <= '0;
    wr(0, 8'h81);
    wr(1, 8'h40);
    wr(2, 8'h40);
    wr(3, 8'h40);
    wr(4, 8'h00);
    wr(5, 8'h01);
    irq_req_i <= 15'h0001;
    take <= 1'b1;
    repeat (4) @(posedge clock_i);
    take <= 1'b0;
    repeat (2) @(posedge clock_i);
    chk(irq_o, 32'h0);
    irq_req_i <= 15'h2001;
    repeat (2) @(posedge clock_i);
    chk(irq_sel_o, 32'h7D);
    apb(12'h300, 1'b0, 8'h00);
    chk(rd, 32'h0000_027D);
    apb(12'h300, 1'b1, 8'h00);
    chk(er, 32'h1);
    irq_req_i <= 15'h0001;
    repeat (2) @(posedge clock_i);
    chk(irq_o, 32'h0);
    ret <= 1'b1;
    @(posedge clock_i);
    ret <= 1'b0;
    repeat (3) @(posedge clock_i);
    chk(irq_sel_o, 32'h50);
    wrap_up();
  end
endmodule
`default_nettype wire

/* src/iepr_pkg.sv */
// constants and types for the interrupt enable and priority register set
package iepr_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CORE_EN     = 8'hA8;
  localparam logic [7:0] IDX_PERIPH_EN   = 8'hB1;
  localparam logic [7:0] IDX_PERIPH_PL   = 8'hB2;
  localparam logic [7:0] IDX_PERIPH_PH   = 8'hB3;
  localparam logic [7:0] IDX_CORE_PH     = 8'hB7;
  localparam logic [7:0] IDX_CORE_PL     = 8'hB8;
  localparam logic [7:0] IDX_STATUS      = 8'hC0;

  // writable bit masks; reserved bits are dropped and read zero
  localparam logic [7:0] CORE_EN_MASK    = 8'hFF;
  localparam logic [7:0] PERIPH_MASK     = 8'h5F;
  localparam logic [7:0] CORE_PRIO_MASK  = 8'h7F;

  // global enable position in the core enable register
  localparam int unsigned GLOBAL_EN_BIT  = 7;

  // values after reset
  localparam logic [7:0] REG_RESET       = 8'h00;
  localparam logic [3:0] SVC_RESET       = 4'h0;

  // source count and sources that really exist
  localparam int unsigned NSRC           = 15;
  localparam logic [14:0] SRC_PRESENT    = 15'h2FFF;
  localparam int unsigned FIRST_PERIPH   = 7;

  // status register field positions
  localparam int unsigned ST_INDEX_LSB   = 0;
  localparam int unsigned ST_LEVEL_LSB   = 4;
  localparam int unsigned ST_VALID_BIT   = 6;
  localparam int unsigned ST_SVC_LSB     = 8;

  // selected request handed to the core
  typedef struct packed {
    logic       valid;
    logic [1:0] level;
    logic [3:0] index;
  } iepr_sel_type;

  localparam iepr_sel_type SEL_RESET = '{valid: 1'b0, level: 2'h0, index: 4'h0};

endpackage

/* src/iepr_regs.sv */
// interrupt enable and priority registers with level arbitration
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ns
`default_nettype none

// Contract
// - the USB request is taken only while enable bit 6 is one.
// - enable bit 4 gates the keyboard request.
// - enable bit 3 gates the converter request.
// - enable bits 2, 1 and 0 gate SPI, two-wire and card requests.
// - bits 7 and 5 of the peripheral enable and priority registers read zero.
// - bit 7 of the core priority registers is undefined and must be ignored.
// - each source has a two-bit level split over a high and a low register.
// - core priority bits 6..0 belong to audio, decoder, serial, timer 1, ext 1, timer 0, ext 0.
// - peripheral priority bits 6,4,3,2,1,0 belong to USB, keyboard, ADC, SPI, two-wire, card.
// - a clear global enable masks all sources, a set one defers to each enable.
// - equal levels are resolved by polling index, index 0 highest, index 14 lowest.
module iepr_regs
  import iepr_pkg::*;
#(
  parameter int unsigned ADDR_W = 12
) (
  // clock and reset
  input  wire logic              clock_i,
  input  wire logic              reset_n_i,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // request flags by polling index
  input  wire logic [NSRC-1:0]   irq_req_i,
  // core vectoring handshake
  input  wire logic              irq_ack_i,
  input  wire logic              irq_reti_i,
  output logic                   irq_o,
  output iepr_sel_type           irq_sel_o,
  // enables seen by the peripherals
  output logic                   usb_irq_enable_o,
  output logic                   kbd_irq_enable_o,
  output logic                   adc_irq_enable_o,
  output logic                   spi_irq_enable_o,
  output logic                   twi_irq_enable_o,
  output logic                   card_irq_enable_o
);

  // bit of the enable or priority register that belongs to a source
  function automatic logic [2:0] src_bit(input int unsigned idx);
    logic [2:0] b;
    b = 3'h0;
    if (idx < FIRST_PERIPH) begin
      b = 3'(idx);
    end else begin
      case (idx)
        7:       b = 3'h0;
        8:       b = 3'h1;
        9:       b = 3'h2;
        10:      b = 3'h3;
        11:      b = 3'h4;
        13:      b = 3'h6;
        default: b = 3'h7;
      endcase
    end
    return b;
  endfunction

  // register index from an apb byte address
  function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] a);
    return a[9:2];
  endfunction

  // registers
  logic [7:0]   core_irq_enable_q;
  logic [7:0]   periph_irq_enable_q;
  logic [7:0]   periph_irq_prio_low_q;
  logic [7:0]   periph_irq_prio_high_q;
  logic [7:0]   core_irq_prio_high_q;
  logic [7:0]   core_irq_prio_low_q;
  logic [3:0]   in_service_q;
  logic [3:0]   in_service_d;
  iepr_sel_type sel_q;
  iepr_sel_type sel_d;
  logic [31:0]  rdata_q;
  logic         slverr_q;

  // bus decode
  logic         wr_en;
  logic         setup;
  logic [7:0]   acc_idx;
  logic         acc_hit;
  logic         idx_known;
  logic         word_ok;
  logic         err_d;
  logic [7:0]   wbyte;

  assign setup   = psel & ~penable;
  assign wr_en   = psel & penable & pwrite & ~slverr_q;
  assign acc_idx = reg_index(paddr);
  assign wbyte   = pwdata[7:0];
  assign word_ok = (paddr[ADDR_W-1:10] == '0) & (paddr[1:0] == 2'h0);
  assign acc_hit = idx_known & word_ok;
  assign err_d   = ~acc_hit | (pwrite & (acc_idx == IDX_STATUS));

  always_comb begin
    case (acc_idx)
      IDX_CORE_EN,
      IDX_PERIPH_EN,
      IDX_PERIPH_PL,
      IDX_PERIPH_PH,
      IDX_CORE_PH,
      IDX_CORE_PL,
      IDX_STATUS:    idx_known = 1'b1;
      default:       idx_known = 1'b0;
    endcase
  end

  // one write strobe per register
  logic         wr_core_en;
  logic         wr_periph_en;
  logic         wr_periph_pl;
  logic         wr_periph_ph;
  logic         wr_core_ph;
  logic         wr_core_pl;

  assign wr_core_en   = wr_en & (acc_idx == IDX_CORE_EN);
  assign wr_periph_en = wr_en & (acc_idx == IDX_PERIPH_EN);
  assign wr_periph_pl = wr_en & (acc_idx == IDX_PERIPH_PL);
  assign wr_periph_ph = wr_en & (acc_idx == IDX_PERIPH_PH);
  assign wr_core_ph   = wr_en & (acc_idx == IDX_CORE_PH);
  assign wr_core_pl   = wr_en & (acc_idx == IDX_CORE_PL);

  // core enable register holding the global enable
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      core_irq_enable_q <= REG_RESET;
    end else if (wr_core_en) begin
      core_irq_enable_q <= wbyte & CORE_EN_MASK;
    end
  end

  // peripheral enable register
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      periph_irq_enable_q <= REG_RESET;
    end else if (wr_periph_en) begin
      periph_irq_enable_q <= wbyte & PERIPH_MASK;
    end
  end

  // peripheral priority low register
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      periph_irq_prio_low_q <= REG_RESET;
    end else if (wr_periph_pl) begin
      periph_irq_prio_low_q <= wbyte & PERIPH_MASK;
    end
  end

  // peripheral priority high register
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      periph_irq_prio_high_q <= REG_RESET;
    end else if (wr_periph_ph) begin
      periph_irq_prio_high_q <= wbyte & PERIPH_MASK;
    end
  end

  // core priority high register; bit 7 is not stored
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      core_irq_prio_high_q <= REG_RESET;
    end else if (wr_core_ph) begin
      core_irq_prio_high_q <= wbyte & CORE_PRIO_MASK;
    end
  end

  // core priority low register; bit 7 is not stored
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      core_irq_prio_low_q <= REG_RESET;
    end else if (wr_core_pl) begin
      core_irq_prio_low_q <= wbyte & CORE_PRIO_MASK;
    end
  end

  // per-source enable and level
  logic [NSRC-1:0] src_en;
  logic [1:0]      src_lvl [NSRC];
  logic [NSRC-1:0] pending;

  generate
    for (genvar g = 0; g < NSRC; g++) begin : g_src
      localparam logic [2:0] B = src_bit(g);
      if (g < FIRST_PERIPH) begin : g_core
        assign src_en[g]  = core_irq_enable_q[B];
        assign src_lvl[g] = {core_irq_prio_high_q[B],
                             core_irq_prio_low_q[B]};
      end else begin : g_periph
        assign src_en[g]  = periph_irq_enable_q[B] & SRC_PRESENT[g];
        assign src_lvl[g] = {periph_irq_prio_high_q[B],
                             periph_irq_prio_low_q[B]};
      end
    end
  endgenerate

  // global gate then individual gate
  assign pending = irq_req_i & src_en
                   & {NSRC{core_irq_enable_q[GLOBAL_EN_BIT]}};

  // highest level wins, lower index wins a tie
  logic       best_valid;
  logic [1:0] best_level;
  logic [3:0] best_index;

  always_comb begin
    best_valid = 1'b0;
    best_level = 2'h0;
    best_index = 4'h0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (pending[i] && (!best_valid || src_lvl[i] >= best_level)) begin
        best_valid = 1'b1;
        best_level = src_lvl[i];
        best_index = 4'(i);
      end
    end
  end

  // level of the service routine currently running
  logic       running;
  logic [1:0] run_level;

  always_comb begin
    running   = |in_service_q;
    run_level = 2'h0;
    for (int l = 0; l < 4; l++) begin
      if (in_service_q[l]) begin
        run_level = 2'(l);
      end
    end
  end

  // request stands only above the running level
  always_comb begin
    sel_d       = SEL_RESET;
    sel_d.level = best_level;
    sel_d.index = best_index;
    sel_d.valid = best_valid & (!running || best_level > run_level);
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sel_q <= SEL_RESET;
    end else begin
      sel_q <= sel_d;
    end
  end

  // in-service levels; a return clears the top one, an ack sets wins
  always_comb begin
    in_service_d = in_service_q;
    if (irq_reti_i && running) begin
      in_service_d[run_level] = 1'b0;
    end
    if (irq_ack_i && sel_q.valid) begin
      in_service_d[sel_q.level] = 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      in_service_q <= SVC_RESET;
    end else begin
      in_service_q <= in_service_d;
    end
  end

  // status word: selected request and levels in service
  logic [31:0] status_word;

  always_comb begin
    status_word                    = 32'h0000_0000;
    status_word[ST_INDEX_LSB +: 4] = sel_q.index;
    status_word[ST_LEVEL_LSB +: 2] = sel_q.level;
    status_word[ST_VALID_BIT]      = sel_q.valid;
    status_word[ST_SVC_LSB +: 4]   = in_service_q;
  end

  // read data captured in the setup phase
  logic [31:0] rd_mux;
  logic [31:0] rdata_d;

  assign rdata_d = pwrite ? 32'h0000_0000 : rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (acc_idx)
      IDX_CORE_EN:   rd_mux[7:0] = core_irq_enable_q;
      IDX_PERIPH_EN: rd_mux[7:0] = periph_irq_enable_q;
      IDX_PERIPH_PL: rd_mux[7:0] = periph_irq_prio_low_q;
      IDX_PERIPH_PH: rd_mux[7:0] = periph_irq_prio_high_q;
      IDX_CORE_PH:   rd_mux[7:0] = core_irq_prio_high_q;
      IDX_CORE_PL:   rd_mux[7:0] = core_irq_prio_low_q;
      IDX_STATUS:    rd_mux = status_word;
      default:       rd_mux = 32'h0000_0000;
    endcase
    if (!acc_hit) begin
      rd_mux = 32'h0000_0000;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_q  <= 32'h0000_0000;
      slverr_q <= 1'b0;
    end else if (setup) begin
      rdata_q  <= rdata_d;
      slverr_q <= err_d;
    end
  end

  // outputs
  assign prdata    = rdata_q;
  assign pready    = 1'b1;
  assign pslverr   = slverr_q & psel & penable;
  assign irq_o     = sel_q.valid;
  assign irq_sel_o = sel_q;

  assign usb_irq_enable_o  = periph_irq_enable_q[src_bit(13)];
  assign kbd_irq_enable_o  = periph_irq_enable_q[src_bit(11)];
  assign adc_irq_enable_o  = periph_irq_enable_q[src_bit(10)];
  assign spi_irq_enable_o  = periph_irq_enable_q[src_bit(9)];
  assign twi_irq_enable_o  = periph_irq_enable_q[src_bit(8)];
  assign card_irq_enable_o = periph_irq_enable_q[src_bit(7)];

endmodule

`default_nettype wire
